// ---- inc/hsc_link_if.sv ----
// Purpose: SPI link between status host and device ends
// Assumes: host drives clock, select and data out
// Notes: miso floats high when the device releases it

`timescale 1ns/100ps

interface hsc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  wire miso;

  // released line reads as pulled high
  assign miso = miso_oe_n ? 1'b1 : miso_o;

  modport dev (
    input sclk,
    input cs_n,
    input mosi,
    output miso_o,
    output miso_oe_n
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input miso
  );
endinterface // hsc_link_if

// ---- inc/hsc_pkg.sv ----
// Purpose: shared constants for the status-read link ends
// Assumes: 100 MHz core clock, SPI mode 0, MSB first
// Notes: status word layout (flag byte, tag byte, two aux bytes) is local

package hsc_pkg;

  // ----------------------------------------
  // op-codes, lengths and tags
  // ----------------------------------------
  localparam logic [7:0] OP_STATUS = 8'hc0;
  localparam logic [7:0] OP_FETCH = 8'h02;
  localparam logic [7:0] REQ_LEN = 8'h00;
  localparam logic [7:0] RESP_LEN = 8'h04;
  localparam logic [7:0] TAG_RESET = 8'h00;
  localparam logic [7:0] TAG_HOST_FIRST = 8'h01;
  localparam logic [7:0] TAG_HOST_LAST = 8'hcf;
  localparam logic [7:0] TAG_UNUSED_LO = 8'hf0;
  localparam logic [7:0] TAG_NULL = 8'hff;

  // ----------------------------------------
  // integrity byte
  // ----------------------------------------
  localparam logic [7:0] CRC_SEED = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] SUM_SEED = 8'h00;

  // ----------------------------------------
  // frame: 4 request bytes then 8 response bytes
  // ----------------------------------------
  localparam logic [6:0] REQ_BITS = 7'h20;
  localparam logic [6:0] FRAME_BITS = 7'h60;
  localparam logic [3:0] IDX_CHECK = 4'h3;
  localparam logic [3:0] IDX_RESP0 = 4'h4;
  localparam logic [3:0] IDX_RESP_CRC = 4'hb;

  // ----------------------------------------
  // status flag byte bit positions
  // ----------------------------------------
  localparam int ST_COMM = 0;
  localparam int ST_CMD = 1;
  localparam int ST_BIST = 2;
  localparam int ST_OPER = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_INPROG = 5;
  localparam int ST_RDAVAIL = 6;
  localparam int ST_EMERG = 7;

  // ----------------------------------------
  // host register map and link timing
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_WORD = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_HALF_NS = 60;
  localparam int LINK_HALF_CYCLES = LINK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

endpackage

// ---- rtl/hsc_device_end.sv ----
// Purpose: device end; serves the status read in one fixed-length frame
// Assumes: link pins are asynchronous to core_clk_i
// Notes: frame is 12 bytes, request then echo/length/status/integrity

`timescale 1ns/100ps

module hsc_device_end
  import hsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // link
  hsc_link_if.dev link,
  // strap
  input wire logic integrity_method_select_pin_i,
  // system status
  input wire logic [7:0] status_flags_i,
  input wire logic [15:0] status_aux_i,
  input wire logic exec_tag_valid_i,
  input wire logic [7:0] exec_tag_i,
  input wire logic status_clear_i,
  input wire logic emergency_shutdown_i,
  // outputs
  output logic host_irq_o,
  output logic status_served_o
);

  // ----------------------------------------
  // synchronisers: {strap, mosi, cs_n, sclk}
  // ----------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic sclk_old_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sync1_q <= 4'h2;
      sync2_q <= 4'h2;
      sclk_old_q <= 1'b0;
    end else begin
      sync1_q <= {integrity_method_select_pin_i, link.mosi, link.cs_n, link.sclk};
      sync2_q <= sync1_q;
      sclk_old_q <= sync2_q[0];
    end
  end

  wire cs_idle = sync2_q[1];
  wire mosi_s = sync2_q[2];
  wire rise = sync2_q[0] && !sclk_old_q && !cs_idle;
  wire fall = !sync2_q[0] && sclk_old_q && !cs_idle;

  // ----------------------------------------
  // integrity method, caught once after startup
  // ----------------------------------------
  logic [1:0] strap_cnt_q;
  logic method_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      strap_cnt_q <= 2'h0;
      method_q <= 1'b0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= 2'(strap_cnt_q + 2'h1);
      if (strap_cnt_q == STRAP_SETTLE) begin
        method_q <= sync2_q[3];
      end
    end
  end

  // ----------------------------------------
  // bit and byte reception
  // ----------------------------------------
  logic [6:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] op_q;
  logic [7:0] tag_rx_q;
  logic [7:0] len_q;

  wire [3:0] byte_idx = bit_cnt_q[6:3];
  wire [7:0] rx_byte = {rx_q[6:0], mosi_s};
  wire byte_done = rise && (bit_cnt_q[2:0] == 3'h7);
  wire check_now = byte_done && (byte_idx == IDX_CHECK);
  wire [7:0] acc;
  wire req_good = (acc == rx_byte);
  wire op_known = (op_q == OP_STATUS) && (len_q == REQ_LEN);

  always_ff @(posedge core_clk_i) begin
    if (reset_i || cs_idle) begin
      bit_cnt_q <= 7'h0;
    end else if (rise) begin
      bit_cnt_q <= 7'(bit_cnt_q + 7'h1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rx_q <= 8'h00;
      op_q <= 8'h00;
      tag_rx_q <= 8'h00;
      len_q <= 8'h00;
    end else if (rise) begin
      rx_q <= rx_byte;
      if (byte_done && byte_idx == 4'h0) op_q <= rx_byte;
      if (byte_done && byte_idx == 4'h1) tag_rx_q <= rx_byte;
      if (byte_done && byte_idx == 4'h2) len_q <= rx_byte;
    end
  end

  // ----------------------------------------
  // status tag and own error flags
  // ----------------------------------------
  logic [7:0] status_tag_q;
  logic comm_err_q;
  logic cmd_err_q;

  // the reset code 00h and the unused codes f0h and up are reported as the null tag
  wire tag_bad = (exec_tag_i == TAG_RESET) || (exec_tag_i >= TAG_UNUSED_LO);
  wire [7:0] tag_in = tag_bad ? TAG_NULL : exec_tag_i;
  wire comm_set = check_now && !req_good;
  wire cmd_set = check_now && req_good && !op_known;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status_tag_q <= TAG_RESET;
      comm_err_q <= 1'b0;
      cmd_err_q <= 1'b0;
    end else begin
      // a new event wins over a clear in the same cycle
      if (exec_tag_valid_i) status_tag_q <= tag_in;
      else if (status_clear_i) status_tag_q <= TAG_RESET;
      comm_err_q <= comm_set || (comm_err_q && !status_clear_i);
      cmd_err_q <= cmd_set || (cmd_err_q && !status_clear_i);
    end
  end

  logic [7:0] own_flags;
  always_comb begin
    own_flags = 8'h00;
    own_flags[ST_COMM] = comm_err_q;
    own_flags[ST_CMD] = cmd_err_q;
    own_flags[ST_EMERG] = emergency_shutdown_i;
  end

  wire [31:0] status_word = {status_flags_i | own_flags, status_tag_q, status_aux_i};

  // ----------------------------------------
  // response, snapshot taken when the request closes
  // ----------------------------------------
  logic [7:0] echo_tag_q;
  logic [31:0] snap_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      echo_tag_q <= TAG_NULL;
      snap_q <= 32'h0;
    end else if (check_now) begin
      echo_tag_q <= req_good ? tag_rx_q : TAG_NULL;
      snap_q <= status_word;
    end
  end

  // fixed order: op, tag, length 4, four status bytes, integrity
  wire [63:0] resp_vec = {op_q, echo_tag_q, RESP_LEN, snap_q, acc};
  wire [2:0] resp_k = 3'(byte_idx - IDX_RESP0);
  wire [7:0] resp_byte = resp_vec[6'(63 - 8 * resp_k) -: 8];
  wire in_resp = (bit_cnt_q >= REQ_BITS) && (bit_cnt_q < FRAME_BITS);
  wire load_evt = fall && (bit_cnt_q[2:0] == 3'h0) && in_resp;
  wire feed_resp = load_evt && (byte_idx != IDX_RESP_CRC);
  wire feed_req = byte_done && (byte_idx < IDX_CHECK);

  hsc_integrity_acc hsc_integrity_acc_inst (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .method_i(method_q),
    .clear_i(cs_idle || check_now),
    .byte_valid_i(feed_req || feed_resp),
    .byte_i(load_evt ? resp_byte : rx_byte),
    .acc_o(acc)
  );

  // ----------------------------------------
  // miso shift-out on falling edges, hardware only
  // ----------------------------------------
  logic [7:0] tx_q;
  logic miso_q;
  logic miso_oe_n_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tx_q <= 8'h00;
      miso_q <= 1'b1;
      miso_oe_n_q <= 1'b1;
    end else begin
      miso_oe_n_q <= cs_idle;
      if (load_evt) begin
        tx_q <= resp_byte;
        miso_q <= resp_byte[7];
      end else if (fall) begin
        tx_q <= {tx_q[6:0], 1'b0};
        miso_q <= tx_q[6];
      end
    end
  end

  assign link.miso_o = miso_q;
  assign link.miso_oe_n = miso_oe_n_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      host_irq_o <= 1'b0;
      status_served_o <= 1'b0;
    end else begin
      host_irq_o <= emergency_shutdown_i;
      status_served_o <= check_now;
    end
  end

endmodule // hsc_device_end

// ---- rtl/hsc_host_end.sv ----
// Purpose: host end; issues status reads on command from an AXI4-Lite port
// Assumes: device end answers within the same 12-byte frame
// Notes: the link clock is divided from core_clk_i and driven out
//
// How it works
// - status request starts with op-code c0h
// - host sends request length zero
// - device echoes received op-code then tag
// - response length four, then four status bytes
// - response integrity covers echo, length, status
// - status read served in hardware, fixed time
// - i2c variant: write, stop, read back; only the SPI link is built here
// - poll until status tag equals sent tag
// - read-data-available flag gates data fetch; the host only reports the flag and has no fetch
// - emergency flag in status plus interrupt line
// - comm or cmd error fails the request
// - status after fetch shows fetch failure
// - only comm and cmd errors mean failure
// - integrity method chosen by startup strap
// - crc-8, polynomial 07h, seed ffh
// - checksum is byte sum, low eight bits
// - every command carries a tag byte
// - tags run 01h to cfh, wrap
// - status tag 00h after init or clear
// - batch and diagnostic tag ranges reserved
// - tag ffh means unknown; host never sends
// - data fetch op-code 02h, length header; OP_FETCH is defined but the host never sends a fetch frame
// - wait until busy and in-progress clear

`timescale 1ns/100ps

module hsc_host_end
  import hsc_pkg::*;
#(
  parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // link
  hsc_link_if.host link,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PREP = 2'b01,
    ST_XFER = 2'b10,
    ST_CLOSE = 2'b11
  } hsc_state_type;

  hsc_state_type state_q;

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  logic [3:0] awaddr_q;
  logic aw_hold_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_hold_q;

  wire wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid_o;
  wire wr_ctrl = wr_fire && (awaddr_q == REG_CTRL) && wstrb_q[0];
  wire wr_stat = wr_fire && (awaddr_q == REG_STATUS) && wstrb_q[0];
  wire wr_hit = (awaddr_q == REG_CTRL) || (awaddr_q == REG_STATUS) || (awaddr_q == REG_WORD);
  wire go = wr_ctrl && wdata_q[0] && (state_q == ST_IDLE);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      awaddr_q <= 4'h0;
      aw_hold_q <= 1'b0;
      s_axi_awready_o <= 1'b1;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      awaddr_q <= s_axi_awaddr_i;
      aw_hold_q <= 1'b1;
      s_axi_awready_o <= 1'b0;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      w_hold_q <= 1'b0;
      s_axi_wready_o <= 1'b1;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      wdata_q <= s_axi_wdata_i;
      wstrb_q <= s_axi_wstrb_i;
      w_hold_q <= 1'b1;
      s_axi_wready_o <= 1'b0;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // tag numbering and method
  // ----------------------------------------
  logic [7:0] tag_q;
  logic [7:0] sent_tag_q;
  logic method_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tag_q <= TAG_HOST_FIRST;
      sent_tag_q <= TAG_RESET;
      method_q <= 1'b0;
    end else begin
      if (wr_ctrl) method_q <= wdata_q[1];
      if (go) begin
        sent_tag_q <= tag_q;
        tag_q <= (tag_q == TAG_HOST_LAST) ? TAG_HOST_FIRST : 8'(tag_q + 8'h1);
      end
    end
  end

  // ----------------------------------------
  // link timing and frame sequencing
  // ----------------------------------------
  logic [1:0] miso_sync1_q;
  logic miso_s;
  logic [7:0] div_q;
  logic [6:0] bit_cnt_q;
  logic [1:0] prep_q;
  logic [31:0] tx_q;
  logic [63:0] rx_q;
  logic sclk_q;
  logic cs_n_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      miso_sync1_q <= 2'h3;
      miso_s <= 1'b1;
    end else begin
      miso_sync1_q <= {miso_sync1_q[0], link.miso};
      miso_s <= miso_sync1_q[1];
    end
  end

  wire half_tick = (div_q == 8'(HALF_CYCLES - 1));
  // sample at the end of the high phase: the device moves miso only after falling edges
  wire fall_evt = (state_q == ST_XFER) && half_tick && sclk_q;
  wire rise_evt = (state_q == ST_XFER) && half_tick && !sclk_q;
  wire [7:0] rx_byte = {rx_q[6:0], miso_s};
  wire [3:0] byte_idx = bit_cnt_q[6:3];
  wire rx_done = fall_evt && (bit_cnt_q[2:0] == 3'h7) && (byte_idx >= IDX_RESP0);
  wire last_bit = fall_evt && (bit_cnt_q == 7'(FRAME_BITS - 7'h1));
  wire [7:0] acc;
  wire [7:0] prep_byte = (prep_q == 2'h0) ? OP_STATUS : ((prep_q == 2'h1) ? sent_tag_q : REQ_LEN);
  wire prep_end = (state_q == ST_PREP) && (prep_q == 2'h3);

  // the write that starts a frame may also change the method: seed with the new one
  hsc_integrity_acc hsc_integrity_acc_inst (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .method_i(go ? wdata_q[1] : method_q),
    .clear_i(go || prep_end),
    .byte_valid_i(((state_q == ST_PREP) && !prep_end) || (rx_done && byte_idx != IDX_RESP_CRC)),
    .byte_i((state_q == ST_PREP) ? prep_byte : rx_byte),
    .acc_o(acc)
  );

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      prep_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (go) begin
          state_q <= ST_PREP;
          prep_q <= 2'h0;
        end
        ST_PREP: begin
          prep_q <= 2'(prep_q + 2'h1);
          if (prep_end) state_q <= ST_XFER;
        end
        ST_XFER: if (last_bit) state_q <= ST_CLOSE;
        ST_CLOSE: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i || state_q != ST_XFER || half_tick) begin
      div_q <= 8'h0;
    end else begin
      div_q <= 8'(div_q + 8'h1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      bit_cnt_q <= 7'h0;
      tx_q <= 32'h0;
      rx_q <= 64'h0;
    end else if (prep_end) begin
      cs_n_q <= 1'b0;
      bit_cnt_q <= 7'h0;
      tx_q <= {OP_STATUS, sent_tag_q, REQ_LEN, acc};
    end else if (rise_evt) begin
      sclk_q <= 1'b1;
    end else if (fall_evt) begin
      sclk_q <= 1'b0;
      bit_cnt_q <= 7'(bit_cnt_q + 7'h1);
      tx_q <= {tx_q[30:0], 1'b0};
      rx_q <= {rx_q[62:0], miso_s};
    end else if (state_q == ST_CLOSE) begin
      cs_n_q <= 1'b1;
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = tx_q[31];

  // ----------------------------------------
  // result checks
  // ----------------------------------------
  wire [7:0] r_op = rx_q[63:56];
  wire [7:0] r_tag = rx_q[55:48];
  wire [7:0] r_len = rx_q[47:40];
  wire [31:0] r_word = rx_q[39:8];
  wire resp_err = (r_op != OP_STATUS) || (r_tag != sent_tag_q) || (r_len != RESP_LEN) || (rx_q[7:0] != acc);

  logic [31:0] word_q;
  logic done_q;
  logic resp_err_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      word_q <= 32'h0;
      done_q <= 1'b0;
      resp_err_q <= 1'b0;
    end else if (state_q == ST_CLOSE) begin
      word_q <= r_word;
      done_q <= 1'b1;
      resp_err_q <= resp_err;
    end else if (wr_stat && wdata_q[1]) begin
      done_q <= 1'b0;
    end
  end

  wire [7:0] st_flags = word_q[31:24];
  wire tag_match = (word_q[23:16] == sent_tag_q);
  wire cmd_fail = st_flags[ST_COMM] || st_flags[ST_CMD];
  wire ready_cmd = !st_flags[ST_BUSY] && !st_flags[ST_INPROG];
  wire [31:0] stat_word = {16'h0, sent_tag_q, ready_cmd, st_flags[ST_EMERG], st_flags[ST_RDAVAIL],
                           cmd_fail, tag_match, resp_err_q, done_q, state_q != ST_IDLE};

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  wire rd_ctrl = (s_axi_araddr_i == REG_CTRL);
  wire rd_stat = (s_axi_araddr_i == REG_STATUS);
  wire rd_word = (s_axi_araddr_i == REG_WORD);
  wire [31:0] rd_mux = rd_ctrl ? {30'h0, method_q, 1'b0} : (rd_stat ? stat_word : (rd_word ? word_q : 32'h0));

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_mux;
      s_axi_rresp_o <= (rd_ctrl || rd_stat || rd_word) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

endmodule // hsc_host_end

// ---- rtl/hsc_integrity_acc.sv ----
// Purpose: running CRC-8 or additive checksum over a byte stream
// Assumes: method is stable while a stream is accumulated
// Notes: clear reloads the seed of the selected method

`timescale 1ns/100ps

module hsc_integrity_acc
  import hsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // control
  input wire logic method_i,
  input wire logic clear_i,
  // byte stream
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic [7:0] acc_o
);

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  wire [7:0] seed = method_i ? SUM_SEED : CRC_SEED;
  wire [7:0] sum_next = 8'(acc_o + byte_i);
  wire [7:0] acc_next = method_i ? sum_next : crc_step(acc_o, byte_i);

  always_ff @(posedge core_clk_i) begin
    if (reset_i || clear_i) begin
      acc_o <= seed;
    end else if (byte_valid_i) begin
      acc_o <= acc_next;
    end
  end

endmodule // hsc_integrity_acc

// ---- tb/host_status_read_crc_tag_logic_bench.sv ----
// Purpose: self-checking bench for both link ends
// Assumes: host method register matches the strap unless a clash is meant
// Notes: the wire is shifted in at sclk rises for byte checks
`timescale 1ns/100ps
module host_status_read_crc_tag_logic_bench
  import hsc_pkg::*;
;
  logic core_clk_i = 1'b0, reset_i = 1'b1, strap = 1'b0, etv = 1'b0, sclr = 1'b0, emerg = 1'b0;
  logic [7:0] flags = 8'h40, etag = 8'h00;
  logic [15:0] aux = 16'h1234;
  logic irq, served, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic aw_r, w_r, b_v, ar_r, r_v;
  logic [3:0] aw_a = 4'h0, ar_a = 4'h0;
  logic [31:0] w_d = 32'h0, r_d;
  logic [1:0] b_resp, r_resp, resp;
  logic [95:0] mo, mi;
  int failures = 0, num_checks = 0, served_cnt = 0;
  hsc_link_if link();
  hsc_device_end hsc_device_end_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link),
    .integrity_method_select_pin_i(strap), .status_flags_i(flags), .status_aux_i(aux),
    .exec_tag_valid_i(etv), .exec_tag_i(etag), .status_clear_i(sclr), .emergency_shutdown_i(emerg),
    .host_irq_o(irq), .status_served_o(served));
  hsc_host_end hsc_host_end_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_r), .s_axi_wdata_i(w_d),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r), .s_axi_bresp_o(b_resp),
    .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
    .s_axi_arready_o(ar_r), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v),
    .s_axi_rready_i(r_r));
  hsc_link_sva hsc_link_sva_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n));
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (served) served_cnt++;
  always @(posedge link.sclk) begin
    if (!link.cs_n) begin
      mo <= {mo[94:0], link.mosi};
      mi <= {mi[94:0], link.miso};
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] integ(input logic [55:0] v, input int n, input logic m);
    logic [7:0] c;
    c = m ? SUM_SEED : CRC_SEED;
    for (int i = n - 1; i >= 0; i--) begin
      if (m) c = c + v[i*8+:8];
      else begin
        c = c ^ v[i*8+:8];
        repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!b_v);
    resp = b_resp;
    b_r <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (ar_r) ar_v <= 1'b0;
    end while (!r_v);
    d = r_d;
    resp = r_resp;
    r_r <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic frame(input logic [31:0] ctrl);
    logic [31:0] s;
    wr(REG_CTRL, ctrl);
    do rd(REG_STATUS, s); while (s[1] !== 1'b1);
    wr(REG_STATUS, 32'h2);
  endtask
  task automatic tag_in(input logic [7:0] t);
    etag <= t;
    etv <= 1'b1;
    @(posedge core_clk_i);
    etv <= 1'b0;
  endtask
  task automatic rst(input logic v);
    reset_i <= 1'b1;
    strap <= v;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_basic();
    logic [31:0] s;
    logic [55:0] e;
    frame(32'h1);
    chk(mo[95:64], {OP_STATUS, 8'h01, REQ_LEN, integ({32'h0, OP_STATUS, 8'h01, REQ_LEN}, 3, 1'b0)}, "req");
    e = {OP_STATUS, 8'h01, RESP_LEN, 8'h40, TAG_RESET, 16'h1234};
    chk(mi[63:0], {e, integ(e, 7, 1'b0)}, "resp");
    chk(served_cnt, 1, "served pulse");
    rd(REG_STATUS, s);
    chk(s[15:8], 8'h01, "tag sent");
    chk(s[5], 1'b1, "data avail");
    chk(s[3], 1'b0, "early match");
    tag_in(8'h02);
    frame(32'h1);
    rd(REG_STATUS, s);
    chk(s[15:8], 8'h02, "next tag");
    chk(s[3], 1'b1, "tag match");
    chk(s[2], 1'b0, "crc ok");
    $display("basic done");
  endtask
  task automatic t_flags();
    logic [31:0] s;
    flags <= 8'h0c;
    tag_in(8'hf0);
    frame(32'h1);
    rd(REG_STATUS, s);
    chk(s[4], 1'b0, "bist only");
    chk(s[7], 1'b1, "idle");
    rd(REG_WORD, s);
    chk(s[23:16], TAG_NULL, "null tag");
    flags <= 8'hb1;
    emerg <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(irq, 1'b1, "irq");
    frame(32'h1);
    rd(REG_STATUS, s);
    chk(s[4], 1'b1, "comm err");
    chk(s[6], 1'b1, "emergency");
    chk(s[7], 1'b0, "busy");
    flags <= 8'h00;
    emerg <= 1'b0;
    sclr <= 1'b1;
    @(posedge core_clk_i);
    sclr <= 1'b0;
    frame(32'h1);
    rd(REG_WORD, s);
    chk(s[23:16], TAG_RESET, "cleared tag");
    rd(4'hc, s);
    chk({s, resp}, {32'h0, RESP_SLVERR}, "unmapped");
    $display("flags done");
  endtask
  task automatic t_sum();
    logic [31:0] s;
    logic [55:0] e;
    rst(1'b1);
    frame(32'h3);
    e = {OP_STATUS, 8'h01, RESP_LEN, 8'h00, TAG_RESET, 16'h1234};
    chk(mi[63:0], {e, integ(e, 7, 1'b1)}, "sum resp");
    rd(REG_STATUS, s);
    chk(s[2], 1'b0, "sum ok");
    frame(32'h1);
    rd(REG_STATUS, s);
    chk(s[2], 1'b1, "method clash");
    $display("sum done");
  endtask
  initial begin
    rst(1'b0);
    t_basic();
    t_flags();
    t_sum();
    results();
  end
  initial begin
    #500000;
    failures++;
    $display("BAD %0t watchdog", $time);
    results();
  end
endmodule // host_status_read_crc_tag_logic_bench

// ---- tb/hsc_link_sva.sv ----
// Purpose: link checks between the host and device ends
// Assumes: SPI mode 0, half period of 6 core clocks
// Notes: bit count follows sclk rises seen by core_clk_i
`timescale 1ns/100ps
module hsc_link_sva
  import hsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  logic sclk_q;
  logic [6:0] cnt_q;
  wire logic rise = sclk & ~sclk_q;
  wire logic [6:0] cnt_d = cs_n ? 7'h00 : cnt_q + {6'h00, rise};
  always_ff @(posedge core_clk_i) begin
    sclk_q <= sclk;
    cnt_q <= cnt_d;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_idle_clock_low: assert property (cs_n |-> !sclk) else $error("sclk high outside frame");
  a_half_period: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk) else $error("bad high phase");
  a_frame_bits: assert property ($rose(cs_n) |-> cnt_q == FRAME_BITS) else $error("bad frame length");
  a_opcode_sent: assert property (rise && cnt_q < 7'h08 |-> mosi == OP_STATUS[7 - cnt_q[2:0]])
    else $error("bad op-code bit");
  a_len_zero: assert property (rise && cnt_q[6:3] == 4'h2 |-> !mosi) else $error("request length not zero");
  a_op_echo: assert property (rise && cnt_q[6:3] == 4'h4 |-> miso == OP_STATUS[7 - cnt_q[2:0]])
    else $error("bad op-code echo");
  a_len_four: assert property (rise && cnt_q[6:3] == 4'h6 |-> miso == RESP_LEN[7 - cnt_q[2:0]])
    else $error("bad response length");
  a_miso_drive: assert property (!cs_n [*4] |-> !miso_oe_n) else $error("miso not driven");
  a_miso_free: assert property (cs_n [*4] |-> miso_oe_n) else $error("miso not released");
  cover property ($rose(cs_n));
  cover property (rise && cnt_q == 7'h5f);
  cover property ($rose(miso_oe_n));
endmodule // hsc_link_sva
